// ==== verilog/rcc_reset_cause.sv ====
/*
 * Reset cause and control register with an Avalon-MM slave, sticky
 * interrupt status with mask, watchdog enable and regulator control.
 * Assumes event inputs are one-clock pulses or levels on clk, except
 * external_clear_pin_n and fuse_watchdog_on which are synchronised.
 */
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
// Behaviour
// - trap conflict reset sets bit 15; zero means none occurred.
// - illegal opcode, addressing mode or bad pointer reset sets bit 14.
// - bits 13 to 9 are unimplemented and always read zero.
// - keep bit 0 puts regulator in standby during sleep; 1 keeps active.
// - on large variants keep bit has no effect but reads back written value.
// - external clear pin assertion sets bit 7.
// - software reset instruction sets bit 6; zero if never executed.
// - soft enable bit 5 turns the watchdog on or off.
// - fuse watchdog on forces watchdog enabled regardless of soft enable.
// - watchdog time-out sets bit 4.
// - entering sleep sets bit 3 for software to see after wake.
// - entering idle sets bit 2.
// - brown-out reset sets bit 1.
// - power-on reset sets bit 0; zero if none since cleared.
// - software may write every flag either way without causing reset.
`timescale 1ns/1ns
module rcc_reset_cause
  import rcc_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [RCC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [RCC_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [RCC_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire rcc_evt_s cause_evt,
  input wire logic external_clear_pin_n,
  input wire logic fuse_watchdog_on,
  input wire logic sleep_active,
  output logic wdt_enable,
  output logic regulator_standby,
  output logic irq
);

  rcc_cause_s cause;
  logic [RCC_REG_W-1:0] irq_status;
  logic [RCC_REG_W-1:0] irq_mask;
  logic [1:0] pin_sync;
  logic [1:0] fuse_sync;

  // two-flop synchronisers for pin and fuse levels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_sync <= 2'h3;
      fuse_sync <= 2'h0;
    end else begin
      pin_sync <= {pin_sync[0], external_clear_pin_n};
      fuse_sync <= {fuse_sync[0], fuse_watchdog_on};
    end
  end

  wire pin_asserted = ~pin_sync[1];

  // hardware events in register layout
  wire [RCC_REG_W-1:0] evt_vec = {cause_evt.trap_conflict,
                                  cause_evt.illegal_op,
                                  6'h00,
                                  pin_asserted,
                                  cause_evt.sw_reset,
                                  1'b0,
                                  cause_evt.wdt_timeout,
                                  cause_evt.sleep_entered,
                                  cause_evt.idle_entered,
                                  cause_evt.brownout,
                                  cause_evt.power_on};

  // bus decode
  wire access_go = ~avs_waitrequest;
  wire do_write = avs_write & access_go;
  wire sel_cause = avs_address == RCC_OFS_CAUSE;
  wire sel_status = avs_address == RCC_OFS_IRQ_STATUS;
  wire sel_mask = avs_address == RCC_OFS_IRQ_MASK;
  wire [RCC_REG_W-1:0] lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [RCC_REG_W-1:0] wdata = avs_writedata[RCC_REG_W-1:0];
  wire [RCC_REG_W-1:0] wr_cause = (do_write & sel_cause) ? lane_mask : 16'h0000;
  wire [RCC_REG_W-1:0] wr_status = (do_write & sel_status) ? lane_mask : 16'h0000;
  wire [RCC_REG_W-1:0] wr_mask = (do_write & sel_mask) ? lane_mask : 16'h0000;

  // software writes any cause flag value, storage only; status bits clear on a written 1; events win over writes
  wire [RCC_REG_W-1:0] cause_written =
    ((cause & ~wr_cause) | (wdata & wr_cause)) & RCC_IMPL_MASK;
  wire [RCC_REG_W-1:0] next_cause = cause_written | (evt_vec & RCC_EVT_MASK);
  wire [RCC_REG_W-1:0] next_status =
    ((irq_status & ~(wr_status & wdata)) | evt_vec) & RCC_EVT_MASK;
  wire [RCC_REG_W-1:0] next_mask =
    ((irq_mask & ~wr_mask) | (wdata & wr_mask)) & RCC_EVT_MASK;

  wire [RCC_REG_W-1:0] rd_sel = sel_cause ? (cause & RCC_IMPL_MASK) :
                                sel_status ? irq_status :
                                sel_mask ? irq_mask : 16'h0000;
  wire next_wait = ~((avs_read | avs_write) & avs_waitrequest);

  // watchdog on when fuse forces it or software enables it
  wire next_wdt = fuse_sync[1] | cause.wdt_soft_enable;
  // large variant: keep bit stored but regulator ignores it
  wire keep_eff = cause.regulator_sleep_keep & ~LARGE_VARIANT;
  wire next_standby = sleep_active & ~keep_eff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cause <= RCC_CAUSE_RESET;
      irq_status <= RCC_STATUS_RESET;
      irq_mask <= RCC_MASK_RESET;
    end else begin
      cause <= next_cause;
      irq_status <= next_status;
      irq_mask <= next_mask;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      wdt_enable <= 1'b0;
      regulator_standby <= 1'b0;
      irq <= 1'b0;
    end else begin
      avs_waitrequest <= next_wait;
      avs_readdata <= {16'h0000, rd_sel};
      wdt_enable <= next_wdt;
      regulator_standby <= next_standby;
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule

// ==== common/rcc_pkg.sv ====
/*
 * Package of the reset cause status block: register offsets, field
 * positions, reset values and the packed types shared by the design.
 * Assumes a 32-bit Avalon-MM bus with byte addresses.
 */
package rcc_pkg;

  localparam int RCC_ADDR_W = 4;
  localparam int RCC_DATA_W = 32;
  localparam int RCC_REG_W = 16;

  // register byte offsets
  localparam logic [RCC_ADDR_W-1:0] RCC_OFS_CAUSE = 4'h0;
  localparam logic [RCC_ADDR_W-1:0] RCC_OFS_IRQ_STATUS = 4'h4;
  localparam logic [RCC_ADDR_W-1:0] RCC_OFS_IRQ_MASK = 4'h8;

  // field positions of reset_cause_control
  localparam int RCC_BIT_TRAP = 15;
  localparam int RCC_BIT_ILLOP = 14;
  localparam int RCC_BIT_KEEP = 8;
  localparam int RCC_BIT_PIN = 7;
  localparam int RCC_BIT_SWR = 6;
  localparam int RCC_BIT_WDTEN = 5;
  localparam int RCC_BIT_WDT_TIMEOUT_FLAG = 4;
  localparam int RCC_BIT_SLEEP = 3;
  localparam int RCC_BIT_IDLE = 2;
  localparam int RCC_BIT_BROWN = 1;
  localparam int RCC_BIT_POWER = 0;

  // implemented bits; 13..9 always read zero
  localparam logic [RCC_REG_W-1:0] RCC_IMPL_MASK = 16'hC1FF;
  // bits that hardware events can set (also the interrupt layout)
  localparam logic [RCC_REG_W-1:0] RCC_EVT_MASK = 16'hC0DF;
  localparam logic [RCC_REG_W-1:0] RCC_CAUSE_RESET = 16'h0003;
  localparam logic [RCC_REG_W-1:0] RCC_STATUS_RESET = 16'h0000;
  localparam logic [RCC_REG_W-1:0] RCC_MASK_RESET = 16'h0000;

  typedef struct packed {
    logic trap_conflict_flag;
    logic illegal_op_flag;
    logic [4:0] unused;
    logic regulator_sleep_keep;
    logic pin_reset_flag;
    logic sw_reset_flag;
    logic wdt_soft_enable;
    logic wdt_timeout_flag;
    logic low_power_stop_flag;
    logic halt_wake_flag;
    logic brownout_flag;
    logic power_up_flag;
  } rcc_cause_s;

  typedef struct packed {
    logic trap_conflict;
    logic illegal_op;
    logic sw_reset;
    logic wdt_timeout;
    logic sleep_entered;
    logic idle_entered;
    logic brownout;
    logic power_on;
  } rcc_evt_s;

endpackage

// ==== verif/rcc_reset_cause_asserts.sv ====
/* port checker of rcc_reset_cause.
   assumes a bind to every instance of the design. */
`timescale 1ns/1ns
module rcc_reset_cause_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic fuse_watchdog_on,
  input wire logic sleep_active,
  input wire logic wdt_enable,
  input wire logic regulator_standby,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer");
  AST_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("long answer");
  AST_ACK: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("stray answer");
  AST_ZERO: assert property (!avs_waitrequest |-> avs_readdata[13:9] == 5'h00)
    else $error("bits 13..9 set");
  AST_FUSE: assert property (fuse_watchdog_on [*4] |-> wdt_enable)
    else $error("fuse ignored");
  AST_WDT_UP: assert property ($rose(wdt_enable) |->
    $past(fuse_watchdog_on, 3) || $past(avs_write && !avs_waitrequest, 2))
    else $error("watchdog on uncaused");
  AST_STBY_UP: assert property ($rose(regulator_standby) |-> $past(sleep_active))
    else $error("standby uncaused");
  AST_STBY_OFF: assert property (!sleep_active |=> !regulator_standby)
    else $error("standby awake");
  cover property ($rose(irq));
  cover property ($rose(wdt_enable));
  cover property ($rose(regulator_standby));
endmodule
bind rcc_reset_cause rcc_reset_cause_asserts chk (.*);

// ==== verif/rcc_reset_cause_bench.sv ====
/* self-checking bench of rcc_reset_cause.
   assumes the package and the bound checker. */
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %0t %h %h", $time, a, e); end end
module rcc_reset_cause_bench import rcc_pkg::*; ;
  logic clk = 0, resetn = 0, rd = 0, wr = 0, pin_n = 1, fuse = 0, slp = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, q, rdat;
  logic ws, wdt, stby, irq, stby_big;
  rcc_evt_s evt = '0;
  int err_total = 0, comparisons = 0;
  rcc_reset_cause uut (.clk(clk), .resetn(resetn), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
    .avs_waitrequest(ws), .cause_evt(evt), .external_clear_pin_n(pin_n),
    .fuse_watchdog_on(fuse), .sleep_active(slp), .wdt_enable(wdt),
    .regulator_standby(stby), .irq(irq));
  // large variant: keep bit must not hold the regulator active
  rcc_reset_cause #(.LARGE_VARIANT(1'b1)) uut_big (.clk(clk), .resetn(resetn),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hF), .avs_readdata(), .avs_waitrequest(), .cause_evt(evt),
    .external_clear_pin_n(pin_n), .fuse_watchdog_on(fuse), .sleep_active(slp),
    .wdt_enable(), .regulator_standby(stby_big), .irq());
  initial forever #2 clk = ~clk;
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= {16'h0000, d};
    do @(posedge clk); while (ws !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic pulse(input logic [7:0] e);
    @(posedge clk);
    evt <= rcc_evt_s'(e);
    @(posedge clk);
    evt <= '0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_cause;
    int pos[8] = '{15, 14, 6, 4, 3, 2, 1, 0};
    bus(0, 4'h0, 0);
    `CHK(q, 32'h0003)
    for (int i = 0; i < 8; i++) begin
      bus(1, 4'h0, 16'h0000);
      pulse(8'h80 >> i);
      bus(0, 4'h0, 0);
      `CHK(q, 32'h1 << pos[i])
    end
    bus(1, 4'h0, 16'h0000);
    pin_n <= 1'b0;
    repeat (2) @(posedge clk);
    pin_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(0, 4'h0, 0);
    `CHK(q, 32'h0080)
    bus(1, 4'h0, 16'hFFFF);
    bus(0, 4'h0, 0);
    `CHK(q, 32'hC1FF)
  endtask
  task automatic t_ctrl;
    bus(1, 4'h0, 16'h0000);
    repeat (2) @(posedge clk);
    `CHK(wdt, 1'b0)
    bus(1, 4'h0, 16'h0020);
    repeat (2) @(posedge clk);
    `CHK(wdt, 1'b1)
    bus(1, 4'h0, 16'h0000);
    fuse <= 1'b1;
    slp <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK(wdt, 1'b1)
    `CHK(stby, 1'b1)
    bus(1, 4'h0, 16'h0100);
    repeat (2) @(posedge clk);
    `CHK(stby, 1'b0)
    `CHK(stby_big, 1'b1)
    fuse <= 1'b0;
    slp <= 1'b0;
  endtask
  task automatic t_irq;
    // drop status left over from the cause scenario
    bus(1, 4'h4, 16'hFFFF);
    bus(1, 4'h8, 16'h0001);
    pulse(8'h80);
    `CHK(irq, 1'b0)
    pulse(8'h01);
    `CHK(irq, 1'b1)
    bus(1, 4'h4, 16'h0001);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    bus(0, 4'hC, 0);
    `CHK(q, 32'h0)
  endtask
  task automatic stop_test;
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_cause;
    t_ctrl;
    t_irq;
    stop_test;
  end
endmodule
